// ===== bench/host_pm_model.sv
// host power manager and negative rail comparator seen by the controller
// assumes the bench sets the requests right after a rising edge
`timescale 1ns/100ps
module host_pm_model #(
  parameter int RAIL_DLY = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pump_en,
  input wire logic tie_mode,
  input wire logic shutdown_input,
  input wire logic awake_req,
  input wire logic sleep_n_req,
  input wire logic rail_block,
  output logic force_awake,
  output logic force_sleep_n,
  output logic rail_ok_raw
);
  logic [7:0] rail_cnt_r;
  // rail charges only while pumps run and is treated as gone at once when they stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rail_cnt_r <= 8'h00;
    else if (!pump_en) rail_cnt_r <= 8'h00;
    else if (rail_cnt_r < 8'(RAIL_DLY)) rail_cnt_r <= rail_cnt_r + 8'h01;
  end
  assign rail_ok_raw = (rail_cnt_r >= 8'(RAIL_DLY)) && !rail_block;
  assign force_awake = tie_mode ? shutdown_input : awake_req;
  assign force_sleep_n = tie_mode ? shutdown_input : sleep_n_req;
endmodule : host_pm_model

// ===== bench/line_power_props.sv
// assertions on the pins of the line activity power controller
// assumes one hclk domain and the bench's shortened idle and wake counts
`timescale 1ns/100ps
module line_power_props
  import power_ctl_pkg::*;
#(
  parameter logic [IDLE_W-1:0] IDLE_CYCLES = IDLE_CYC_DEF[IDLE_W-1:0],
  parameter logic [WAKE_W-1:0] WAKE_CYCLES = WAKE_CYC_DEF[WAKE_W-1:0]
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic force_awake,
  input wire logic force_sleep_n,
  input wire logic rail_ok_raw,
  input wire logic [NUM_DRV-1:0] drv_in,
  input wire logic [NUM_RCV-1:0] rcv_in,
  input wire logic [NUM_RCV-1:0] rcv_valid_in,
  input wire logic [NUM_DRV-1:0] drv_oe,
  input wire logic [NUM_RCV-1:0] rcv_oe,
  input wire logic ring_monitor_output,
  input wire logic line_signal_present,
  input wire logic pump_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [IDLE_W-1:0] quiet_r;
  logic [15:0] wake_r;
  // quiet span is an upper bound on the idle timer, since the timer also waits for ACTIVE
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_r <= '0;
    else if (!pump_en || $changed({drv_in, rcv_in})) quiet_r <= '0;
    else quiet_r <= quiet_r + 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wake_r <= 16'h0000;
    else if (!pump_en) wake_r <= 16'h0000;
    else if (!drv_oe[0]) wake_r <= wake_r + 16'h0001;
  end
  present_tracks_a: assert property ($stable(rcv_valid_in) [*8] |-> line_signal_present == |rcv_valid_in)
    else $error("line present flag does not follow receivers");
  ring_live_a: assert property ($stable(rcv_in[0]) [*8] |-> ring_monitor_output == rcv_in[0])
    else $error("ring monitor not following receiver zero");
  forced_off_a: assert property (!force_sleep_n [*8] |-> !pump_en && drv_oe == '0 && rcv_oe == '0)
    else $error("forced off left something driving");
  forced_on_a: assert property ((force_awake && force_sleep_n) [*8] |-> pump_en && rcv_oe == '1)
    else $error("forced on let the part sleep");
  rail_gate_a: assert property (!rail_ok_raw [*8] |-> drv_oe == '0)
    else $error("drivers on without rail");
  sleep_rcv_a: assert property (force_sleep_n [*8] ##0 $fell(pump_en) |-> drv_oe == '0 && rcv_oe == '1)
    else $error("auto sleep output enables wrong");
  idle_span_a: assert property ((force_sleep_n && !force_awake) [*8] ##0 $fell(pump_en)
    |-> quiet_r >= IDLE_CYCLES - 1'b1)
    else $error("slept before idle time ran out");
  wake_edge_a: assert property (force_sleep_n [*8] ##0 (!pump_en && rcv_oe[0] && $changed({drv_in, rcv_in}))
    |-> ##[1:8] pump_en)
    else $error("edge in auto sleep did not wake");
  wake_span_a: assert property ($rose(drv_oe[0]) |-> wake_r >= 16'(WAKE_CYCLES) - 16'h0001)
    else $error("drivers enabled before wake time");
  cover property ($fell(pump_en) && rcv_oe[0]);
  cover property ($rose(drv_oe[0]));
  cover property (!force_sleep_n && line_signal_present);
endmodule : line_power_props
bind line_activity_power_control line_power_props #(.IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES))
  line_power_props_i (.hclk(hclk), .hresetn(hresetn), .force_awake(force_awake), .force_sleep_n(force_sleep_n),
  .rail_ok_raw(rail_ok_raw), .drv_in(drv_in), .rcv_in(rcv_in), .rcv_valid_in(rcv_valid_in), .drv_oe(drv_oe),
  .rcv_oe(rcv_oe), .ring_monitor_output(ring_monitor_output), .line_signal_present(line_signal_present),
  .pump_en(pump_en));

// ===== bench/testbench.sv
// self-checking bench: registers, idle sleep, wake, line detector, forced modes
// assumes hreadyout feeds hready and a shortened idle and wake count
`timescale 1ns/100ps
module testbench;
  import power_ctl_pkg::*;
  localparam logic [IDLE_W-1:0] IDLE = 33'h0C8;
  localparam logic [WAKE_W-1:0] WAKE = 13'h00A;
  localparam logic [31:0] DRV_ALL = (32'h1 << NUM_DRV) - 32'h1;
  localparam logic [31:0] RCV_ALL = (32'h1 << NUM_RCV) - 32'h1;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq, pump_en, ring_monitor_output, line_signal_present;
  logic tie_mode = 1'b0, shutdown_input = 1'b0, awake_req = 1'b0, sleep_n_req = 1'b1, rail_block = 1'b0;
  logic force_awake, force_sleep_n, rail_ok_raw;
  logic [NUM_DRV-1:0] drv_in = '0, drv_out, drv_oe;
  logic [NUM_RCV-1:0] rcv_in = '0, rcv_valid_in = '0, rcv_out, rcv_oe;
  int n_fail = 0, total_checks = 0, n;
  always #2 hclk = ~hclk;
  line_activity_power_control #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) line_activity_power_control_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .force_awake(force_awake), .force_sleep_n(force_sleep_n), .rail_ok_raw(rail_ok_raw), .drv_in(drv_in),
    .rcv_in(rcv_in), .rcv_valid_in(rcv_valid_in), .drv_out(drv_out), .drv_oe(drv_oe), .rcv_out(rcv_out),
    .rcv_oe(rcv_oe), .ring_monitor_output(ring_monitor_output), .line_signal_present(line_signal_present),
    .pump_en(pump_en), .irq(irq));
  host_pm_model host_pm_model_i (.hclk(hclk), .hresetn(hresetn), .pump_en(pump_en), .tie_mode(tie_mode),
    .shutdown_input(shutdown_input), .awake_req(awake_req), .sleep_n_req(sleep_n_req), .rail_block(rail_block),
    .force_awake(force_awake), .force_sleep_n(force_sleep_n), .rail_ok_raw(rail_ok_raw));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task give_verdict();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // single word transfer; read data lands in rd at the data phase edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // sampled at the falling edge so the rising edge updates have landed
  task wait_on(input logic sel, input logic v);
    n = 0;
    while (((sel ? drv_oe[0] : pump_en) !== v) && n < 2000) begin
      @(negedge hclk);
      n++;
    end
  endtask : wait_on
  task ticks(input int k);
    repeat (k) @(negedge hclk);
  endtask : ticks
  task t_regs();
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    check("mask reset", rd, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h7);
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    check("mask", rd, 32'h7);
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    check("okay resp", 32'(hresp), 32'h0);
  endtask : t_regs
  task t_auto();
    wait_on(1'b1, 1'b1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
    ticks(2);
    check("irq cleared", 32'(irq), 32'h0);
    ticks(int'(IDLE) - 50);
    @(posedge hclk);
    drv_in <= 5'h01;
    ticks(100);
    check("timer restart", 32'(pump_en), 32'h1);
    wait_on(1'b0, 1'b0);
    check("idle span", 32'((n + 100 >= int'(IDLE)) && (n + 100 <= int'(IDLE) + 8)), 32'h1);
    check("sleep drv oe", 32'(drv_oe), 32'h0);
    check("sleep rcv oe", 32'(rcv_oe), RCV_ALL);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("sleep event", rd, 32'h1);
    check("irq up", 32'(irq), 32'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    ticks(2);
    check("irq down", 32'(irq), 32'h0);
  endtask : t_auto
  task t_wake();
    @(posedge hclk);
    rail_block <= 1'b1;
    rcv_in <= 3'h2;
    wait_on(1'b0, 1'b1);
    check("wake latency", 32'(n <= 6), 32'h1);
    ticks(int'(WAKE) + 20);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("waits for rail", 32'(rd[1:0]), 32'(ST_WAKING));
    check("no drive", 32'(drv_oe), 32'h0);
    @(posedge hclk);
    rail_block <= 1'b0;
    wait_on(1'b1, 1'b1);
    ticks(2);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("wake event", rd, 32'h2);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
  endtask : t_wake
  task t_present();
    @(posedge hclk);
    rcv_valid_in <= 3'h4;
    ticks(8);
    check("present", 32'(line_signal_present), 32'h1);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("present event", rd, 32'h4);
    @(posedge hclk);
    rcv_valid_in <= 3'h0;
    ticks(8);
    check("absent", 32'(line_signal_present), 32'h0);
  endtask : t_present
  // register restart wakes an auto sleep with no line edge at all
  task t_restart();
    wait_on(1'b0, 1'b0);
    check("idle asleep", 32'(pump_en), 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    wait_on(1'b0, 1'b1);
    check("restart wake", 32'(n <= 2), 32'h1);
    wait_on(1'b1, 1'b1);
    ticks(2);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("restart events", rd, 32'h7);
    check("restart irq", 32'(irq), 32'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
  endtask : t_restart
  task t_forced();
    @(posedge hclk);
    tie_mode <= 1'b1;
    rcv_valid_in <= 3'h1;
    rcv_in <= 3'h1;
    ticks(10);
    check("off outputs", {pump_en, drv_oe, rcv_oe}, 32'h0);
    check("off present", 32'(line_signal_present), 32'h1);
    check("off ring", 32'(ring_monitor_output), 32'h1);
    @(posedge hclk);
    rcv_in <= 3'h0;
    drv_in <= 5'h1E;
    ticks(10);
    check("ring low", 32'(ring_monitor_output), 32'h0);
    check("edges ignored", 32'(pump_en), 32'h0);
    @(posedge hclk);
    shutdown_input <= 1'b1;
    wait_on(1'b1, 1'b1);
    ticks(int'(IDLE) + 50);
    check("forced on", 32'(drv_oe), DRV_ALL);
    check("drv data", 32'(drv_out), 32'h01);
    check("rcv data", 32'(rcv_out), 32'h7);
  endtask : t_forced
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_auto();
    t_wake();
    t_present();
    t_restart();
    t_forced();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    give_verdict();
  end
endmodule : testbench

// ===== hw/edge_if.sv
// synchronised level and edge summary handed from an edge monitor to the controller
// assumes both ends share hclk
`timescale 1ns/100ps
interface edge_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic any_edge;
  modport src (output level, output any_edge);
  modport mon (input level, input any_edge);
endinterface : edge_if

// ===== hw/edge_watch.sv
// two-flop synchroniser and transition detector for a group of pins
// assumes pins are asynchronous to hclk; clock enable freezes every flop
`timescale 1ns/100ps
module edge_watch #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] raw,
  edge_if.src o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;
  logic any_edge_r;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_r <= '0;
      any_edge_r <= 1'b0;
    end else if (ce) begin
      last_r <= sync_r;
      any_edge_r <= |(last_r ^ sync_r);
    end
  end

  assign o.level = last_r;
  assign o.any_edge = any_edge_r;
endmodule : edge_watch

// ===== hw/line_activity_power_control.sv
// power mode controller: idle shutdown, forced modes, line signal detector, AHB-Lite registers
// assumes pin inputs are asynchronous; rail_ok_raw comes from a comparator on the negative pump rail
`timescale 1ns/100ps
// How it works
// RULE_01: idle shutdown runs only with force_sleep_n high and force_awake low.
// RULE_02: thirty idle seconds in automatic mode stops pumps and drivers.
// RULE_03: any receiver or driver edge during automatic shutdown wakes the part.
// RULE_04: line_signal_present is high when any receiver sees valid line levels.
// RULE_05: line_signal_present follows receivers only and stays valid in every mode.
// RULE_06: either force control overrides the automatic logic regardless of activity.
// RULE_07: with no force asserted, time since the last edge picks normal or standby.
// RULE_08: shutdown stops the charge pumps and floats every line driver.
// RULE_09: leaving shutdown takes about 25 us before normal operation.
// RULE_10: drivers enable only once the negative rail magnitude passes about 3 V.
// RULE_11: host may tie both force lines as one shutdown and watch the monitor output.
// RULE_12: force_sleep_n low floats drivers and receivers; only the ring monitor stays driven. Here line_signal_present also stays driven.
// RULE_13: automatic shutdown floats only the drivers; receiver outputs stay active.
// RULE_14: both force controls high keeps everything running, idle timer ignored.
// RULE_15: idle timer restarts on every edge and expires at the thirty second count.
module line_activity_power_control
  import power_ctl_pkg::*;
#(
  parameter logic [IDLE_W-1:0] IDLE_CYCLES = IDLE_CYC_DEF[IDLE_W-1:0],
  parameter logic [WAKE_W-1:0] WAKE_CYCLES = WAKE_CYC_DEF[WAKE_W-1:0]
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic force_awake,
  input wire logic force_sleep_n,
  input wire logic rail_ok_raw,
  input wire logic [NUM_DRV-1:0] drv_in,
  input wire logic [NUM_RCV-1:0] rcv_in,
  input wire logic [NUM_RCV-1:0] rcv_valid_in,
  output logic [NUM_DRV-1:0] drv_out,
  output logic [NUM_DRV-1:0] drv_oe,
  output logic [NUM_RCV-1:0] rcv_out,
  output logic [NUM_RCV-1:0] rcv_oe,
  output logic ring_monitor_output,
  output logic line_signal_present,
  output logic pump_en,
  output logic irq
);
  localparam int CTL_W = 3;

  edge_if #(.W(NUM_DRV)) drv_e ();
  edge_if #(.W(NUM_RCV)) rcv_e ();
  edge_if #(.W(NUM_RCV)) val_e ();
  edge_if #(.W(CTL_W)) ctl_e ();

  edge_watch #(.W(NUM_DRV)) u_drv (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw(drv_in),
    .o(drv_e)
  );
  edge_watch #(.W(NUM_RCV)) u_rcv (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw(rcv_in),
    .o(rcv_e)
  );
  edge_watch #(.W(NUM_RCV)) u_val (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw(rcv_valid_in),
    .o(val_e)
  );
  edge_watch #(.W(CTL_W)) u_ctl (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw({rail_ok_raw, force_sleep_n, force_awake}),
    .o(ctl_e)
  );

  logic awake_s;
  logic sleep_n_s;
  logic rail_ok_s;
  logic forced_off;
  logic forced_on;
  logic auto_mode;
  logic activity;
  logic present_now;
  assign awake_s = ctl_e.level[0];
  assign sleep_n_s = ctl_e.level[1];
  assign rail_ok_s = ctl_e.level[2];
  assign forced_off = !sleep_n_s; // [RULE_06] [RULE_12]
  assign forced_on = sleep_n_s && awake_s; // [RULE_06] [RULE_14]
  assign auto_mode = sleep_n_s && !awake_s; // [RULE_01]
  assign activity = drv_e.any_edge || rcv_e.any_edge; // [RULE_03] [RULE_15]
  assign present_now = |val_e.level; // [RULE_04] [RULE_05]

  // bus address phase capture
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rd_sel;
  logic wr_sel;
  assign rd_sel = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
  assign wr_sel = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (ce) begin
      wr_pend_r <= wr_sel;
      wr_addr_r <= haddr[7:0];
    end
  end

  logic restart_wr;
  logic irq_clr_wr;
  logic mask_wr;
  assign restart_wr = wr_pend_r && (wr_addr_r == ADDR_CTRL) && hwdata[CTRL_RESTART_BIT];
  assign irq_clr_wr = wr_pend_r && (wr_addr_r == ADDR_IRQ_STATUS);
  assign mask_wr = wr_pend_r && (wr_addr_r == ADDR_IRQ_MASK);

  // idle timer and power state
  power_state_t state_r;
  power_state_t state_nxt;
  logic [IDLE_W-1:0] idle_cnt_r;
  logic [WAKE_W-1:0] wake_cnt_r;
  logic idle_expired;
  logic wake_done;
  assign idle_expired = (idle_cnt_r >= IDLE_CYCLES - 1'b1); // [RULE_15] [RULE_02]
  assign wake_done = (wake_cnt_r >= WAKE_CYCLES - 1'b1); // [RULE_09]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (forced_off) begin
          state_nxt = ST_FORCED_OFF; // [RULE_06]
        end else if (auto_mode && idle_expired && !activity) begin
          state_nxt = ST_SLEEP; // [RULE_02] [RULE_07]
        end
      end
      ST_SLEEP: begin
        if (forced_off) begin
          state_nxt = ST_FORCED_OFF;
        end else if (forced_on || activity || restart_wr) begin
          state_nxt = ST_WAKING; // [RULE_03] [RULE_14]
        end
      end
      ST_WAKING: begin
        if (forced_off) begin
          state_nxt = ST_FORCED_OFF;
        end else if (wake_done && rail_ok_s) begin
          state_nxt = ST_ACTIVE; // [RULE_09] [RULE_10]
        end
      end
      ST_FORCED_OFF: begin
        // leaving forced off always powers up; the idle timer starts afresh
        if (!forced_off) begin
          state_nxt = ST_WAKING;
        end
      end
      default: begin
        state_nxt = ST_FORCED_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_FORCED_OFF;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // timer holds at zero outside automatic mode so forcing on never expires it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_r <= '0;
    end else if (ce) begin
      if (activity || restart_wr || !auto_mode || state_r != ST_ACTIVE) begin
        idle_cnt_r <= '0; // [RULE_15] [RULE_14]
      end else if (!idle_expired) begin
        idle_cnt_r <= idle_cnt_r + 1'b1; // [RULE_07]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt_r <= '0;
    end else if (ce) begin
      if (state_r != ST_WAKING) begin
        wake_cnt_r <= '0;
      end else if (!wake_done) begin
        wake_cnt_r <= wake_cnt_r + 1'b1; // [RULE_09]
      end
    end
  end

  // line side outputs, registered from the next state so they change with it
  logic pump_nxt;
  logic drv_on_nxt;
  logic rcv_on_nxt;
  assign pump_nxt = (state_nxt != ST_SLEEP) && (state_nxt != ST_FORCED_OFF); // [RULE_08]
  assign drv_on_nxt = (state_nxt == ST_ACTIVE) && rail_ok_s; // [RULE_08] [RULE_10] [RULE_13]
  assign rcv_on_nxt = (state_nxt != ST_FORCED_OFF); // [RULE_12] [RULE_13]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_en <= 1'b0;
      drv_oe <= '0;
      rcv_oe <= '0;
    end else if (ce) begin
      pump_en <= pump_nxt;
      drv_oe <= {NUM_DRV{drv_on_nxt}};
      rcv_oe <= {NUM_RCV{rcv_on_nxt}};
    end
  end

  // translators invert; the monitor copy is non-inverting and never floats
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv_out <= '0;
      rcv_out <= '0;
      ring_monitor_output <= 1'b0;
      line_signal_present <= 1'b0;
    end else if (ce) begin
      drv_out <= ~drv_e.level;
      rcv_out <= ~rcv_e.level;
      ring_monitor_output <= rcv_e.level[0]; // [RULE_12] [RULE_11]
      line_signal_present <= present_now; // [RULE_04] [RULE_05]
    end
  end

  // interrupt events, set wins over write-one-to-clear
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SLEEP_BIT] = (state_r == ST_ACTIVE) && (state_nxt == ST_SLEEP);
    irq_set[IRQ_WAKE_BIT] = (state_r == ST_WAKING) && (state_nxt == ST_ACTIVE);
    irq_set[IRQ_PRESENT_BIT] = (present_now != line_signal_present);
  end
  assign irq_clr = irq_clr_wr ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= '0;
    end else if (ce) begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (ce && mask_wr) begin
      irq_mask_r <= hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // read data is prepared at the address phase, so the bus never waits
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (haddr[7:0])
      ADDR_STATUS: begin
        rd_val[ST_STATE_LSB +: 2] = state_r;
        rd_val[ST_PRESENT_BIT] = line_signal_present;
        rd_val[ST_PUMP_BIT] = pump_en;
        rd_val[ST_DRV_BIT] = drv_oe[0];
        rd_val[ST_RAIL_BIT] = rail_ok_s;
      end
      ADDR_IRQ_STATUS: begin
        rd_val[IRQ_W-1:0] = irq_status_r;
      end
      ADDR_IRQ_MASK: begin
        rd_val[IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ce && rd_sel) begin
      hrdata <= rd_val;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : line_activity_power_control

// ===== hw/power_ctl_pkg.sv
// constants shared by the line activity power controller, its assertions and its bench
// assumes a single 250 MHz bus clock and 32-bit AHB-Lite register access
package power_ctl_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int NUM_DRV = 5;
  localparam int NUM_RCV = 3;

  // times as printed, then cycle counts (least times round up)
  localparam longint IDLE_TIME_S = 30;
  localparam longint NS_PER_S = 64'd1000000000;
  localparam longint WAKE_TIME_NS = 25000;
  localparam logic [63:0] IDLE_CYC_DEF = 64'((IDLE_TIME_S * NS_PER_S + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [63:0] WAKE_CYC_DEF = 64'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int IDLE_W = 33;
  localparam int WAKE_W = 13;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  // control register fields
  localparam int CTRL_RESTART_BIT = 0;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PRESENT_BIT = 2;
  localparam int ST_PUMP_BIT = 3;
  localparam int ST_DRV_BIT = 4;
  localparam int ST_RAIL_BIT = 5;

  // interrupt events
  localparam int IRQ_W = 3;
  localparam int IRQ_SLEEP_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_PRESENT_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // gray coded along sleep -> waking -> active -> forced off -> sleep
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_WAKING = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_FORCED_OFF = 2'h2
  } power_state_t;

endpackage : power_ctl_pkg
